/* shared/core_memory_cycle_control_regs.vh */
// timing, field and code constants for the core memory cycle controller
`ifndef CORE_MEMORY_CYCLE_CONTROL_REGS_VH
`define CORE_MEMORY_CYCLE_CONTROL_REGS_VH

// clock period in picoseconds (200 MHz)
`define CLK_PERIOD_PS      5000
// memory cycle times in nanoseconds
`define FULL_CYCLE_NS      950
`define HALF_CYCLE_NS      500
`define IR_LOAD_NS         475
// cycle counts derived from the times (least times round up)
`define FULL_CYCLE_CLKS    ((`FULL_CYCLE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define HALF_CYCLE_CLKS    ((`HALF_CYCLE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define IR_LOAD_CLKS       ((`IR_LOAD_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// power guard settling delay in cycles
`define GUARD_DELAY_CLKS   64
// location bus fields
`define LOC_WIDTH          15
`define LOC_WORD_MSB       11
`define LOC_STACK_BIT      12
`define LOC_INC_LSB        13
`define LOC_INC_MSB        14
// instruction word fields
`define INS_INDIRECT_BIT   15
`define INS_STORE_BIT      14
`define INS_MEMREF_BIT     13
// operation codes on the cycle request port
`define OP_FETCH           2'h0
`define OP_TRAP_WRITE      2'h1

`endif

/* design/core_memory_cycle_control.v */
// core memory cycle sequencer: fetch, indirect, operand and power guard
`timescale 1ns/1ps
`include "core_memory_cycle_control_regs.vh"

module core_memory_cycle_control #(
    parameter INCREMENTS = 8,                     // fitted increments
    parameter GUARD_DELAY = `GUARD_DELAY_CLKS     // power guard delay
) (
    input  wire        sys_clk_i,                 // system clock
    input  wire        reset_n_i,                 // sync reset, low
    input  wire        run_i,                     // run, else step mode
    input  wire        trap_req_i,                // trap-in write request
    input  wire [14:0] trap_addr_i,               // trap-in location
    input  wire [15:0] trap_data_i,               // trap-in word
    input  wire [14:0] start_addr_i,              // first fetch location
    input  wire [15:0] store_data_i,              // operand to store
    input  wire        sensed_logic_supply_i,     // supply present, pin
    input  wire [15:0] word_bus_n_i,              // word bus in, low=1
    output reg  [14:0] location_bus_o,            // location bus
    output reg  [15:0] word_bus_n_o,              // word bus out, low=1
    output reg         word_bus_oe_o,             // word bus driven
    output reg  [7:0]  start_pulse_o,             // per-increment start
    output reg         clear_write_o,             // 1 clear/write
    output reg         half_cycle_o,              // 1 half cycle
    output reg         data_guard_o,              // 1 inhibit drive
    output reg  [15:0] instruction_o,             // instruction register
    output reg  [15:0] operand_o,                 // operand holding reg
    output reg         execute_o,                 // execute phase pulse
    output wire        instruction_cycle_o,       // fetch cycle active
    output wire        instruction_address_phase_o, // fetch second half
    output wire        operand_cycle_o,           // operand cycle active
    output wire        indirect_address_cycle_o,  // address cycle active
    output reg         timing_control_release_o,  // guard output one
    output reg         data_guard_release_o,      // guard output two
    output reg         system_restart_release_o   // guard output three
);

    // cycle lengths in clocks
    localparam integer FULL_INT  = `FULL_CYCLE_CLKS;   // full cycle clocks
    localparam integer HALF_INT  = `HALF_CYCLE_CLKS;   // half cycle clocks
    localparam integer LOAD_INT  = `IR_LOAD_CLKS;      // read sample clock
    localparam integer GUARD_INT = GUARD_DELAY;        // guard settle clocks
    // counter-width copies, cut on purpose
    localparam [7:0]  FULL_CLKS  = FULL_INT[7:0];
    localparam [7:0]  HALF_CLKS  = HALF_INT[7:0];
    localparam [7:0]  LOAD_CLKS  = LOAD_INT[7:0];
    localparam [15:0] GUARD_CLKS = GUARD_INT[15:0];

    // one-hot sequencer states
    localparam [5:0] ST_IDLE  = 6'h01;            // waiting for run
    localparam [5:0] ST_FETCH = 6'h02;            // instruction cycle
    localparam [5:0] ST_ADDR  = 6'h04;            // indirect address cycle
    localparam [5:0] ST_OPER  = 6'h08;            // operand cycle
    localparam [5:0] ST_TRAP  = 6'h10;            // trap-in half write
    localparam [5:0] ST_GAP   = 6'h20;            // start pulse setup

    // decode increment select bits to a one-hot start pulse
    function [7:0] inc_decode;
        input [14:0] loc;
        begin
            inc_decode = 8'h01 << loc[`LOC_INC_MSB:`LOC_INC_LSB];
        end
    endfunction

    // registers of the sequencer
    reg  [5:0]  state;                            // current state
    reg  [5:0]  ret_state;                        // state after gap
    reg  [7:0]  phase_cnt;                        // clocks into cycle
    reg  [14:0] location;                         // location register
    reg  [14:0] program_cnt;                      // next instruction loc
    reg  [14:0] oper_addr;                        // operand address
    reg         cur_store;                        // current op stores
    reg         cur_write;                        // cycle is clear/write
    reg         cur_half;                         // cycle is half length
    reg         pend_exec;                        // operand awaits execute
    reg         trap_pend;                        // trap-in waiting
    reg  [14:0] trap_loc;                         // held trap location
    reg  [15:0] trap_word;                        // held trap word
    // power guard
    reg         supply_meta;                      // sync stage one
    reg         supply_sync;                      // sync stage two
    reg  [15:0] guard_cnt;                        // settle counter
    reg         guard_on;                         // memory enabled

    // cycle end and sample points
    wire [7:0]  cyc_len = cur_half ? HALF_CLKS : FULL_CLKS;
    wire        cyc_end = (phase_cnt == cyc_len - 8'h01);
    wire        load_pt = (phase_cnt == LOAD_CLKS - 8'h01);
    // last clock of a trap-in write, pending trap consumed here
    wire        trap_done = (state == ST_TRAP) && cyc_end;
    wire        second_half = (phase_cnt >= LOAD_CLKS);
    wire [15:0] read_word = ~word_bus_n_i;        // low level is one

    // phase indications
    assign instruction_cycle_o = (state == ST_FETCH);
    assign instruction_address_phase_o = (state == ST_FETCH) && second_half;
    assign operand_cycle_o = (state == ST_OPER);
    assign indirect_address_cycle_o = (state == ST_ADDR);

    // power guard: synchronise supply sense
    always @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            supply_meta <= 1'b0;
            supply_sync <= 1'b0;
        end else begin
            supply_meta <= sensed_logic_supply_i;
            supply_sync <= supply_meta;
        end
    end

    // power guard: delayed enable on both edges of supply
    always @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            guard_cnt <= 16'h0000;
            guard_on  <= 1'b0;
        end else if (supply_sync == guard_on) begin
            guard_cnt <= 16'h0000;                // stable, no change
        end else if (guard_cnt == GUARD_CLKS - 16'h0001) begin
            guard_cnt <= 16'h0000;
            guard_on  <= supply_sync;
        end else begin
            guard_cnt <= guard_cnt + 16'h0001;
        end
    end

    // power guard outputs follow the delayed enable
    always @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            timing_control_release_o <= 1'b0;
            data_guard_release_o     <= 1'b0;
            system_restart_release_o <= 1'b0;
        end else begin
            timing_control_release_o <= guard_on;
            data_guard_release_o     <= guard_on;
            system_restart_release_o <= guard_on;
        end
    end

    // trap-in request capture, set wins over consumption
    always @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            trap_pend <= 1'b0;
            trap_loc  <= 15'h0000;
            trap_word <= 16'h0000;
        end else if (trap_req_i && (!trap_pend || trap_done)) begin
            // a request landing on the consuming clock is kept
            trap_pend <= 1'b1;
            trap_loc  <= trap_addr_i;
            trap_word <= trap_data_i;
        end else if (trap_done) begin
            trap_pend <= 1'b0;
        end
    end

    // main sequencer
    always @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            state         <= ST_IDLE;
            ret_state     <= ST_FETCH;
            phase_cnt     <= 8'h00;
            location      <= 15'h0000;
            program_cnt   <= 15'h0000;
            oper_addr     <= 15'h0000;
            cur_store     <= 1'b0;
            cur_write     <= 1'b0;
            cur_half      <= 1'b0;
            pend_exec     <= 1'b0;
            instruction_o <= 16'h0000;
            operand_o     <= 16'h0000;
            execute_o     <= 1'b0;
        end else begin
            execute_o <= 1'b0;
            case (state)
            ST_IDLE: begin
                // wait for power guard, then a pending trap-in or run, before cycling
                phase_cnt <= 8'h00;
                if (guard_on && trap_pend) begin
                    location  <= trap_loc;
                    cur_write <= 1'b1;
                    cur_half  <= 1'b1;            // half only for trap
                    ret_state <= ST_TRAP;
                    state     <= ST_GAP;
                end else if (guard_on && run_i) begin
                    location    <= start_addr_i;
                    program_cnt <= start_addr_i + 15'h0001;
                    cur_write   <= 1'b0;
                    cur_half    <= 1'b0;
                    ret_state   <= ST_FETCH;
                    state       <= ST_GAP;
                end
            end
            ST_GAP: begin
                // location settles one clock before the start pulse
                phase_cnt <= 8'h00;
                state     <= ret_state;
            end
            ST_FETCH: begin
                phase_cnt <= phase_cnt + 8'h01;
                if (phase_cnt == 8'h00 && pend_exec) begin
                    execute_o <= 1'b1;            // prior operand used
                    pend_exec <= 1'b0;
                end
                if (load_pt) begin
                    instruction_o <= read_word;
                    cur_store <= read_word[`INS_STORE_BIT];
                    // operand address formed in address phase
                    oper_addr <= {3'h0, read_word[11:0]} |
                                 (location & 15'h7000);
                end
                if (cyc_end) begin
                    phase_cnt <= 8'h00;
                    if (!instruction_o[`INS_MEMREF_BIT]) begin
                        location    <= program_cnt;
                        program_cnt <= program_cnt + 15'h0001;
                        pend_exec   <= 1'b1;
                        state <= run_i ? ST_FETCH : ST_IDLE;
                    end else begin
                        location <= oper_addr;
                        if (instruction_o[`INS_INDIRECT_BIT]) begin
                            cur_write <= 1'b0;
                            state     <= ST_ADDR;
                        end else begin
                            cur_write <= cur_store;
                            state     <= ST_OPER; // at 950
                        end
                    end
                end
            end
            ST_ADDR: begin
                phase_cnt <= phase_cnt + 8'h01;
                if (load_pt) begin
                    operand_o <= read_word;       // indirect word
                end
                if (cyc_end) begin
                    phase_cnt <= 8'h00;
                    location  <= operand_o[14:0]; // resolved address
                    if (!operand_o[`INS_INDIRECT_BIT]) begin
                        cur_write <= cur_store;
                        state     <= ST_OPER;
                    end
                end
            end
            ST_OPER: begin
                phase_cnt <= phase_cnt + 8'h01;
                if (load_pt && !cur_write) begin
                    operand_o <= read_word;       // holding register
                end
                if (cyc_end) begin
                    phase_cnt   <= 8'h00;
                    location    <= program_cnt;   // next fetch at 1900
                    program_cnt <= program_cnt + 15'h0001;
                    pend_exec   <= !cur_write;    // store has none
                    cur_write   <= 1'b0;
                    state <= run_i ? ST_FETCH : ST_IDLE;
                end
            end
            ST_TRAP: begin
                phase_cnt <= phase_cnt + 8'h01;
                if (cyc_end) begin
                    phase_cnt <= 8'h00;
                    cur_write <= 1'b0;
                    cur_half  <= 1'b0;
                    state     <= ST_IDLE;
                end
            end
            default: begin
                state <= ST_IDLE;
            end
            endcase
        end
    end

    // memory control lines and buses, registered
    always @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            location_bus_o <= 15'h0000;
            word_bus_n_o   <= 16'hffff;
            word_bus_oe_o  <= 1'b0;
            start_pulse_o  <= 8'h00;
            clear_write_o  <= 1'b0;
            half_cycle_o   <= 1'b0;
            data_guard_o   <= 1'b1;
        end else begin
            location_bus_o <= location;           // high is one
            clear_write_o  <= cur_write;
            half_cycle_o   <= cur_half;
            // guard held while memory is disabled or idle
            data_guard_o   <= !guard_on || (state == ST_IDLE);
            // single start pulse at cycle origin only
            if (phase_cnt == 8'h00 && state != ST_IDLE && state != ST_GAP &&
                guard_on &&
                location[`LOC_INC_MSB:`LOC_INC_LSB] < INCREMENTS)
                start_pulse_o <= inc_decode(location);
            else
                start_pulse_o <= 8'h00;
            // drive word bus during clear/write cycles
            if (state == ST_TRAP) begin
                word_bus_n_o  <= ~trap_word;
                word_bus_oe_o <= 1'b1;
            end else if (state == ST_OPER && cur_write) begin
                word_bus_n_o  <= ~store_data_i;
                word_bus_oe_o <= 1'b1;
            end else begin
                word_bus_n_o  <= 16'hffff;
                word_bus_oe_o <= 1'b0;
            end
        end
    end

endmodule // core_memory_cycle_control

/* dv/core_memory_cycle_control_chk.sv */
// port assertions for the core memory cycle controller
`timescale 1ns/1ps
module core_memory_cycle_control_chk (
    input logic        sys_clk_i,                 // system clock
    input logic        reset_n_i,                 // sync reset, low
    input logic [14:0] location_bus_o,            // location bus
    input logic [7:0]  start_pulse_o,             // increment starts
    input logic        clear_write_o,             // clear/write select
    input logic        half_cycle_o,              // half cycle select
    input logic        data_guard_o,              // drive inhibit
    input logic        word_bus_oe_o,             // word bus driven
    input logic [15:0] instruction_o,             // instruction reg
    input logic        instruction_cycle_o,       // fetch cycle
    input logic        operand_cycle_o,           // operand cycle
    input logic        indirect_address_cycle_o,  // address cycle
    input logic        timing_control_release_o,  // guard one
    input logic        data_guard_release_o,      // guard two
    input logic        system_restart_release_o   // guard three
);
    logic [8:0] gap;      // clocks since the last start pulse
    logic       seen;     // a start pulse happened since reset
    logic       was_half; // the last cycle started was a half cycle
    // time the spacing of start pulses, saturating at the top
    always @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            gap <= 9'h000;
            seen <= 1'b0;
            was_half <= 1'b0;
        end else if (|start_pulse_o) begin
            gap <= 9'h001;
            seen <= 1'b1;
            was_half <= half_cycle_o;
        end else if (gap != 9'h1ff) begin
            gap <= gap + 9'h001;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    a_one_increment: assert property (
        $onehot0(start_pulse_o)) else $error("several start pulses");
    a_pulse_single: assert property (
        |start_pulse_o |=> start_pulse_o == 8'h00)
        else $error("start pulse too long");
    a_pulse_decode: assert property (
        |start_pulse_o |->
        start_pulse_o == (8'h01 << location_bus_o[14:13]))
        else $error("start pulse not from location bits");
    a_cycle_spacing: assert property (
        |start_pulse_o && seen |-> gap >= (was_half ? 9'h064 : 9'h0be))
        else $error("memory cycle started too soon");
    a_half_trap: assert property (
        half_cycle_o |-> clear_write_o && !instruction_cycle_o &&
        !operand_cycle_o && !indirect_address_cycle_o)
        else $error("half cycle outside a trap write");
    a_guard_blocks: assert property (
        |start_pulse_o |-> timing_control_release_o)
        else $error("cycle while memory disabled");
    a_guard_outputs: assert property (
        timing_control_release_o == data_guard_release_o &&
        data_guard_release_o == system_restart_release_o)
        else $error("guard outputs disagree");
    a_drive_enabled: assert property (
        |start_pulse_o |=> !data_guard_o)
        else $error("drive inhibited in a cycle");
    a_write_drive: assert property (
        word_bus_oe_o |-> clear_write_o)
        else $error("word bus driven in a read cycle");
    a_ir_load_time: assert property (
        $changed(instruction_o) |-> gap == 9'h05e && instruction_cycle_o)
        else $error("instruction loaded off time");
    c_trap: cover property (|start_pulse_o && half_cycle_o);
    c_store: cover property (operand_cycle_o && word_bus_oe_o);
    c_indirect: cover property ($rose(indirect_address_cycle_o));
endmodule // core_memory_cycle_control_chk

/* dv/core_memory_model.sv */
// behavioural core memory increments facing the cycle controller
`timescale 1ns/1ps
module core_memory_model (
    input  logic        sys_clk_i,     // system clock
    input  logic [7:0]  start_pulse_i, // increment start pulses
    input  logic [14:0] location_i,    // location bus, high is one
    input  logic        clear_write_i, // clear/write when high
    input  logic        half_cycle_i,  // half cycle when high
    input  logic        data_guard_i,  // drive inhibit
    input  logic [15:0] word_n_i,      // word bus from controller
    input  logic        word_oe_i,     // controller drives word bus
    output logic [15:0] word_n_o       // word bus to controller
);
    logic [15:0] mem [0:32767]; // stored words, true polarity
    logic [14:0] addr;          // location latched at start
    logic        wr;            // cycle is clear/write
    logic        busy;          // a cycle is in progress
    logic [7:0]  cnt;           // clocks into the cycle
    logic [7:0]  lim;           // length of the cycle
    // empty memory and a moving idle pattern at time zero
    initial begin
        for (int i = 0; i < 32768; i++) mem[i] = 16'h0000;
        busy = 1'b0;
        word_n_o = 16'h5555;
    end
    // one cycle per start pulse; read data only after access time
    always @(posedge sys_clk_i) begin
        if (|start_pulse_i) begin
            addr <= location_i;
            wr <= clear_write_i;
            busy <= 1'b1;
            cnt <= 8'h00;
            lim <= half_cycle_i ? 8'h64 : 8'hbe;
        end else if (busy) begin
            cnt <= cnt + 8'h01;
            busy <= (cnt + 8'h01) < lim;
        end
        if (busy && wr && word_oe_i && !data_guard_i)
            mem[addr] <= ~word_n_i;
        if (busy && !wr && cnt >= 8'h54)
            word_n_o <= ~mem[addr];
        else
            word_n_o <= ~word_n_o;
    end
endmodule // core_memory_model

/* dv/testbench.sv */
// self-checking bench for the core memory cycle controller
`timescale 1ns/1ps
module testbench;
    localparam int GD = 4;               // shortened guard delay
    logic        sys_clk_i = 1'b0;       // 200 MHz clock
    logic        reset_n_i = 1'b0;       // sync reset, low
    logic        run_i = 1'b0;           // run level
    logic        trap_req_i = 1'b0;      // trap-in request
    logic [14:0] trap_addr_i = 15'h0000; // trap-in location
    logic [15:0] trap_data_i = 16'h0000; // trap-in word
    logic [14:0] start_addr_i = 15'h0100; // first fetch location
    logic [15:0] store_data_i = 16'h0f0f; // operand to store
    logic        sensed_logic_supply_i = 1'b0; // supply sense
    logic [15:0] word_bus_n_i, word_bus_n_o, instruction_o, operand_o;
    logic [14:0] location_bus_o;
    logic [7:0]  start_pulse_o;
    logic        word_bus_oe_o, clear_write_o, half_cycle_o;
    logic        data_guard_o, execute_o, instruction_cycle_o;
    logic        instruction_address_phase_o, operand_cycle_o;
    logic        indirect_address_cycle_o, timing_control_release_o;
    logic        data_guard_release_o, system_restart_release_o;
    int          bad_count = 0;          // mismatches
    int          comparisons = 0;        // comparisons made
    int          n;                      // clocks waited
    int          k;                      // address cycles seen
    logic        acc;                    // flag seen over a span
    always #2.5 sys_clk_i = ~sys_clk_i;
    core_memory_cycle_control #(.GUARD_DELAY(GD)) dut (.*);
    core_memory_model mdl (.sys_clk_i(sys_clk_i),
        .start_pulse_i(start_pulse_o), .location_i(location_bus_o),
        .clear_write_i(clear_write_o), .half_cycle_i(half_cycle_o),
        .data_guard_i(data_guard_o), .word_n_i(word_bus_n_o),
        .word_oe_i(word_bus_oe_o), .word_n_o(word_bus_n_i));
    // print the verdict and stop
    task close_out;
        if (bad_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // compare a word
    task cmp(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // compare a flag
    task chk(input logic got, input logic exp);
        cmp({15'h0000, got}, {15'h0000, exp});
    endtask
    // flag chosen by number
    function logic pick(input int s);
        case (s)
            0: pick = |start_pulse_o;
            1: pick = operand_cycle_o;
            2: pick = timing_control_release_o;
            4: pick = instruction_address_phase_o;
            default: pick = execute_o;
        endcase
    endfunction
    // wait a bounded time for a flag to reach a level
    task wt(input int s, input logic v);
        n = 0;
        while (pick(s) !== v) begin
            @(posedge sys_clk_i);
            #1;
            n++;
            if (n > 2000) begin
                bad_count++;
                close_out();
            end
        end
    endtask
    // or a flag over a number of clocks into acc
    task span(input int c, input int s);
        acc = 1'b0;
        repeat (c) begin
            @(posedge sys_clk_i);
            #1;
            acc = acc | pick(s);
        end
    endtask
    // supply comes up: guard outputs rise after the delay
    task t_power_up;
        @(posedge sys_clk_i);
        sensed_logic_supply_i <= 1'b1;
        #1;
        chk(timing_control_release_o | ~data_guard_o, 1'b0);
        wt(2, 1'b1);
        chk(n >= GD && n <= GD + 6, 1'b1);
    endtask
    // trap-in write from idle lands in increment three
    task t_trap;
        @(posedge sys_clk_i);
        trap_req_i <= 1'b1;
        trap_addr_i <= 15'h7300;
        trap_data_i <= 16'hbeef;
        @(posedge sys_clk_i);
        trap_req_i <= 1'b0;
        #1;
        wt(0, 1'b1);
        cmp({8'h00, start_pulse_o}, 16'h0008);
        cmp({1'b0, location_bus_o}, 16'h7300);
        chk(half_cycle_o & clear_write_o, 1'b1);
        repeat (120) @(posedge sys_clk_i);
        cmp(mdl.mem[15'h7300], 16'hbeef);
    endtask
    // direct load, operand used in the next execute phase
    task t_load;
        @(posedge sys_clk_i);
        run_i <= 1'b1;
        #1;
        wt(1, 1'b1);
        wt(0, 1'b1);
        cmp(instruction_o, 16'h2200);
        cmp({1'b0, location_bus_o}, 16'h0200);
        chk(clear_write_o | half_cycle_o, 1'b0);
        wt(1, 1'b0);
        cmp(operand_o, 16'h1234);
        wt(3, 1'b1);
        chk(n <= 4 && instruction_cycle_o, 1'b1);
    endtask
    // store clears and writes, no execute follows
    task t_store;
        chk(instruction_address_phase_o, 1'b0);
        wt(4, 1'b1);
        chk(n >= 92 && n <= 96, 1'b1);
        wt(1, 1'b1);
        wt(0, 1'b1);
        cmp(instruction_o, 16'h6201);
        cmp({1'b0, location_bus_o}, 16'h0201);
        chk(clear_write_o, 1'b1);
        wt(1, 1'b0);
        cmp(mdl.mem[15'h0201], 16'h0f0f);
        span(8, 3);
        chk(acc, 1'b0);
    endtask
    // two chained indirect words, then the operand
    task t_indirect;
        k = 0;
        n = 0;
        while (operand_cycle_o !== 1'b1 && n < 2000) begin
            if (indirect_address_cycle_o && |start_pulse_o) begin
                cmp({1'b0, location_bus_o}, k ? 16'h0204 : 16'h0203);
                k++;
            end
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        if (n >= 2000) begin
            bad_count++;
            close_out();
        end
        wt(0, 1'b1);
        chk(k == 2, 1'b1);
        cmp({1'b0, location_bus_o}, 16'h0205);
        wt(1, 1'b0);
        cmp(operand_o, 16'h5a5a);
    endtask
    // step mode, then supply loss: guard falls, traps refused
    task t_power_down;
        @(posedge sys_clk_i);
        run_i <= 1'b0;
        repeat (800) @(posedge sys_clk_i);
        sensed_logic_supply_i <= 1'b0;
        #1;
        chk(data_guard_o, 1'b1);
        wt(2, 1'b0);
        chk(n >= GD && n <= GD + 6, 1'b1);
        @(posedge sys_clk_i);
        trap_req_i <= 1'b1;
        span(300, 0);
        chk(acc, 1'b0);
    endtask
    // reset, load a small program, run the scenarios
    initial begin
        repeat (10) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        mdl.mem[15'h0100] = 16'h2200;
        mdl.mem[15'h0200] = 16'h1234;
        mdl.mem[15'h0101] = 16'h6201;
        mdl.mem[15'h0102] = 16'ha203;
        mdl.mem[15'h0203] = 16'h8204;
        mdl.mem[15'h0204] = 16'h0205;
        mdl.mem[15'h0205] = 16'h5a5a;
        t_power_up();
        t_trap();
        t_load();
        t_store();
        t_indirect();
        t_power_down();
        close_out();
    end
endmodule // testbench
bind core_memory_cycle_control core_memory_cycle_control_chk chk (.*);
